// ==== verilog/ccr_core_regs.vh ====
// constants for the core working registers and condition flags
`ifndef CCR_CORE_REGS_VH
`define CCR_CORE_REGS_VH

// operation codes from the instruction decoder
`define CCR_OP_W          5
`define CCR_OP_NOP        5'h00
`define CCR_OP_LOAD_IMM   5'h01
`define CCR_OP_ADD        5'h02
`define CCR_OP_SUB        5'h03
`define CCR_OP_AND        5'h04
`define CCR_OP_OR         5'h05
`define CCR_OP_XOR        5'h06
`define CCR_OP_NEQ_TEST   5'h07
`define CCR_OP_COMPARE    5'h08
`define CCR_OP_ROT_LEFT   5'h09
`define CCR_OP_ROT_RIGHT  5'h0A
`define CCR_OP_PROT_LEFT  5'h0B
`define CCR_OP_PROT_RIGHT 5'h0C
`define CCR_OP_SET_CARRY  5'h0D
`define CCR_OP_CLR_CARRY  5'h0E
`define CCR_OP_SET_SWAP   5'h0F
`define CCR_OP_CLR_SWAP   5'h10
`define CCR_OP_WR_PAIR_A  5'h11
`define CCR_OP_WR_PAIR_B  5'h12
`define CCR_OP_TO_PAIR_A  5'h13
`define CCR_OP_TO_PAIR_B  5'h14
`define CCR_OP_FROM_PAIR_A 5'h15
`define CCR_OP_FROM_PAIR_B 5'h16
`define CCR_OP_BRANCH     5'h17

// software register port indexes
`define CCR_ADDR_W        3
`define CCR_ADDR_WORK     3'h0
`define CCR_ADDR_ROW      3'h1
`define CCR_ADDR_COL      3'h2
`define CCR_ADDR_TABLE    3'h3
`define CCR_ADDR_PERIPH   3'h4
`define CCR_ADDR_FLAGS    3'h5

// flag register bit positions
`define CCR_FLAG_SWAP     0
`define CCR_FLAG_CARRY    1
`define CCR_FLAG_BRANCH   2

// reset value of the pair swap flag
`define CCR_SWAP_RESET    1'b0

`endif

// ==== verilog/ccr_core_regs.v ====
// working nibble, pointer registers and condition flags of the core
//
// Notes on behaviour
// - 4-bit work nibble: operands, results, rotate, transfers
// - work nibble has no reset value
// - row register alone or with column as pointer
// - row, column, table, periph registers not reset
// - table register general or ROM table address
// - periph register general or peripheral number
// - swap flag picks row/column or table/periph
// - set-swap sets, clear-swap clears swap flag
// - reset clears swap flag
// - addition writes carry out to carry flag
// - subtraction writes inverted borrow to carry
// - rotates go through carry with a register
// - set-carry forces 1, clear-carry forces 0
// - carry held to next instruction, not reset
// - carry-producing ops copy carry to branch flag
// - zero logic or not-equal result clears branch
// - zero compare result clears branch flag
// - all other executed ops set branch flag
// - branch taken when branch flag is one
// - branch flag held to next instruction
// - branch flag has no reset value
//
// limitations and intent:
// - only the pair swap flag and the read port have a reset; every
//   other register powers up unknown, so software must load it first
// - an executing op always beats a software write in the same cycle;
//   the software write is then lost, not delayed to a later cycle
// - unknown op codes behave as a no-op that sets the branch flag
// - rotates of another register use pair a, steered by the swap flag
// - the pointer outputs are plain register copies, so the ram, rom
//   and peripheral sides see a change one edge after the op
// - reads have no side effects; polling the flags never moves them
// - the swap flag only steers ops that come after the swap op
//
// Decided for this implementation: the address-and-strobe port and the address map.

`include "ccr_core_regs.vh"

module ccr_core_regs (
   // clock and reset
   input  wire                   clock,
   input  wire                   arst_n,
   // instruction decoder
   input  wire                   op_valid,
   input  wire [`CCR_OP_W-1:0]   op_code,
   input  wire [3:0]             op_data,
   // software register port
   input  wire [`CCR_ADDR_W-1:0] sw_addr,
   input  wire [3:0]             sw_wdata,
   input  wire                   sw_write,
   input  wire                   sw_read,
   output reg  [3:0]             sw_rdata,
   // register and flag state
   output reg  [3:0]             work_nibble,
   output reg                    pair_swap_flag,
   output reg                    carry_flag,
   output reg                    branch_cond_flag,
   // pointers towards ram, rom and peripherals
   output wire [7:0]             ram_addr,
   output wire [3:0]             rom_table_nib,
   output wire [3:0]             periph_reg_n,
   output wire [3:0]             pair_a_value,
   output wire [3:0]             pair_b_value,
   output wire                   branch_take
);

   // pointer registers, no reset by design
   reg  [3:0] ram_row;
   reg  [3:0] ram_col;
   reg  [3:0] table_reg;
   reg  [3:0] periph_sel;

   // next values of the execution step
   reg  [3:0] next_work;
   reg        next_carry;
   reg        next_branch;
   reg        next_swap;
   reg  [3:0] next_pair_a;
   reg  [3:0] next_pair_b;
   reg        work_we;
   reg        pair_a_we;
   reg        pair_b_we;
   reg  [4:0] sum;

   // 4-bit add with carry in, carry out in bit 4
   // one function so add, subtract and compare share one carry chain
   function [4:0] nib_add;
      input [3:0] a;
      input [3:0] b;
      input       cin;
      begin
         nib_add = {1'b0, a} + {1'b0, b} + {4'h0, cin};
      end
   endfunction

   // pick one member of a register pair by the swap flag
   // used for both pair members so the two can never disagree
   function [3:0] pair_pick;
      input       swap;
      input [3:0] plain_reg;
      input [3:0] alt_reg;
      begin
         pair_pick = swap ? alt_reg : plain_reg;
      end
   endfunction

   // nonzero test of a logic or compare result, zero clears branch
   function nib_nonzero;
      input [3:0] v;
      begin
         nib_nonzero = |v;
      end
   endfunction

   // software write aimed at one index; an executing op blocks it, so
   // a write that collides with an instruction is dropped, not queued
   function sw_hit;
      input                   wr;
      input                   busy;
      input [`CCR_ADDR_W-1:0] addr;
      input [`CCR_ADDR_W-1:0] idx;
      begin
         sw_hit = wr && !busy && (addr == idx);
      end
   endfunction

   // decoded software writes, one per register index
   wire       wr_work;
   wire       wr_row;
   wire       wr_col;
   wire       wr_table;
   wire       wr_periph;
   wire       wr_flags;
   assign wr_work   = sw_hit(sw_write, op_valid, sw_addr, `CCR_ADDR_WORK);
   assign wr_row    = sw_hit(sw_write, op_valid, sw_addr, `CCR_ADDR_ROW);
   assign wr_col    = sw_hit(sw_write, op_valid, sw_addr, `CCR_ADDR_COL);
   assign wr_table  = sw_hit(sw_write, op_valid, sw_addr, `CCR_ADDR_TABLE);
   assign wr_periph = sw_hit(sw_write, op_valid, sw_addr, `CCR_ADDR_PERIPH);
   assign wr_flags  = sw_hit(sw_write, op_valid, sw_addr, `CCR_ADDR_FLAGS);

   assign pair_a_value  = pair_pick(pair_swap_flag, ram_row, table_reg);
   assign pair_b_value  = pair_pick(pair_swap_flag, ram_col, periph_sel);
   assign ram_addr      = {ram_row, ram_col};
   assign rom_table_nib = table_reg;
   assign periph_reg_n  = periph_sel;
   // decoder uses this to branch or fall through
   assign branch_take   = branch_cond_flag;

   // execution step: results and flags of one instruction
   // defaults hold every register and set the branch flag; items
   // override, and the write enables gate the register processes
   always @* begin
      next_work   = work_nibble;
      next_carry  = carry_flag;
      next_branch = 1'b1;
      next_swap   = pair_swap_flag;
      next_pair_a = pair_a_value;
      next_pair_b = pair_b_value;
      work_we     = 1'b0;
      pair_a_we   = 1'b0;
      pair_b_we   = 1'b0;
      sum         = 5'h00;
      case (op_code)
         `CCR_OP_LOAD_IMM: begin
            next_work = op_data;
            work_we   = 1'b1;
         end
         `CCR_OP_ADD: begin
            sum         = nib_add(work_nibble, op_data, 1'b0);
            next_work   = sum[3:0];
            next_carry  = sum[4];
            next_branch = sum[4];
            work_we     = 1'b1;
         end
         `CCR_OP_SUB: begin
            // a - b as a + ~b + 1: bit 4 is the inverted borrow
            sum         = nib_add(work_nibble, ~op_data, 1'b1);
            next_work   = sum[3:0];
            next_carry  = sum[4];
            next_branch = sum[4];
            work_we     = 1'b1;
         end
         `CCR_OP_AND: begin
            // logic ops keep carry; branch tells a zero result
            next_work   = work_nibble & op_data;
            next_branch = nib_nonzero(next_work);
            work_we     = 1'b1;
         end
         `CCR_OP_OR: begin
            next_work   = work_nibble | op_data;
            next_branch = nib_nonzero(next_work);
            work_we     = 1'b1;
         end
         `CCR_OP_XOR: begin
            next_work   = work_nibble ^ op_data;
            next_branch = nib_nonzero(next_work);
            work_we     = 1'b1;
         end
         `CCR_OP_NEQ_TEST: begin
            // test only, the work nibble keeps its value
            next_branch = nib_nonzero(work_nibble ^ op_data);
         end
         `CCR_OP_COMPARE: begin
            // difference is only tested, carry is left alone
            sum         = nib_add(work_nibble, ~op_data, 1'b1);
            next_branch = nib_nonzero(sum[3:0]);
         end
         // rotate through carry: the bit shifted out lands in carry
         `CCR_OP_ROT_LEFT: begin
            next_work   = {work_nibble[2:0], carry_flag};
            next_carry  = work_nibble[3];
            next_branch = work_nibble[3];
            work_we     = 1'b1;
         end
         `CCR_OP_ROT_RIGHT: begin
            next_work   = {carry_flag, work_nibble[3:1]};
            next_carry  = work_nibble[0];
            next_branch = work_nibble[0];
            work_we     = 1'b1;
         end
         // pair a follows the swap flag, so one op serves both pairs
         `CCR_OP_PROT_LEFT: begin
            next_pair_a = {pair_a_value[2:0], carry_flag};
            next_carry  = pair_a_value[3];
            next_branch = pair_a_value[3];
            pair_a_we   = 1'b1;
         end
         `CCR_OP_PROT_RIGHT: begin
            next_pair_a = {carry_flag, pair_a_value[3:1]};
            next_carry  = pair_a_value[0];
            next_branch = pair_a_value[0];
            pair_a_we   = 1'b1;
         end
         // carry forcing counts as carry-producing: branch follows
         `CCR_OP_SET_CARRY: begin
            next_carry  = 1'b1;
            next_branch = 1'b1;
         end
         `CCR_OP_CLR_CARRY: begin
            next_carry  = 1'b0;
            next_branch = 1'b0;
         end
         `CCR_OP_SET_SWAP:  next_swap = 1'b1;
         `CCR_OP_CLR_SWAP:  next_swap = 1'b0;
         // pair writes and transfers leave carry untouched
         `CCR_OP_WR_PAIR_A: begin
            next_pair_a = op_data;
            pair_a_we   = 1'b1;
         end
         `CCR_OP_WR_PAIR_B: begin
            next_pair_b = op_data;
            pair_b_we   = 1'b1;
         end
         `CCR_OP_TO_PAIR_A: begin
            next_pair_a = work_nibble;
            pair_a_we   = 1'b1;
         end
         `CCR_OP_TO_PAIR_B: begin
            next_pair_b = work_nibble;
            pair_b_we   = 1'b1;
         end
         `CCR_OP_FROM_PAIR_A: begin
            next_work = pair_a_value;
            work_we   = 1'b1;
         end
         `CCR_OP_FROM_PAIR_B: begin
            next_work = pair_b_value;
            work_we   = 1'b1;
         end
         // the decoder reads branch_take for the branch op itself
         default: begin
            // nop and branch touch nothing but the branch flag
            next_work = work_nibble;
         end
      endcase
   end

   // swap flag: the only flag with a reset value
   // a software write cannot race a set or clear op: the op wins
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         pair_swap_flag <= `CCR_SWAP_RESET;
      end else if (op_valid) begin
         pair_swap_flag <= next_swap;
      end else if (wr_flags) begin
         pair_swap_flag <= sw_wdata[`CCR_FLAG_SWAP];
      end
   end

   // carry and branch flags: no reset, change when an op executes or on a flags index write
   // software may preload both flags through the flags index
   always @(posedge clock) begin
      if (op_valid) begin
         carry_flag       <= next_carry;
         branch_cond_flag <= next_branch;
      end else if (wr_flags) begin
         carry_flag       <= sw_wdata[`CCR_FLAG_CARRY];
         branch_cond_flag <= sw_wdata[`CCR_FLAG_BRANCH];
      end
   end
   // the flags above stay unknown until first written

   // work nibble: no reset, op wins over a software write
   // even an op that leaves the nibble alone blocks the write
   always @(posedge clock) begin
      if (op_valid && work_we) begin
         work_nibble <= next_work;
      end else if (wr_work) begin
         work_nibble <= sw_wdata;
      end
   end

   // ram row: general register or high half of the ram pointer; only
   // written by ops while the swap flag selects the row/column pair
   always @(posedge clock) begin
      if (op_valid && pair_a_we && !pair_swap_flag) begin
         ram_row <= next_pair_a;
      end else if (wr_row) begin
         ram_row <= sw_wdata;
      end
   end

   // ram column: general register or low half of the ram pointer,
   // steered like the row, as the other member of the pair
   always @(posedge clock) begin
      if (op_valid && pair_b_we && !pair_swap_flag) begin
         ram_col <= next_pair_b;
      end else if (wr_col) begin
         ram_col <= sw_wdata;
      end
   end

   // table register: general or rom table address nibble; only
   // written by ops while the swap flag selects the alternate pair
   always @(posedge clock) begin
      if (op_valid && pair_a_we && pair_swap_flag) begin
         table_reg <= next_pair_a;
      end else if (wr_table) begin
         table_reg <= sw_wdata;
      end
   end

   // periph select: general or peripheral register number; shares
   // its steering with the table register
   always @(posedge clock) begin
      if (op_valid && pair_b_we && pair_swap_flag) begin
         periph_sel <= next_pair_b;
      end else if (wr_periph) begin
         periph_sel <= sw_wdata;
      end
   end

   // read data stands one cycle after the strobe, zero otherwise
   // returning zero between reads keeps stale data off the port
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         sw_rdata <= 4'h0;
      end else if (sw_read) begin
         case (sw_addr)
            `CCR_ADDR_WORK:   sw_rdata <= work_nibble;
            `CCR_ADDR_ROW:    sw_rdata <= ram_row;
            `CCR_ADDR_COL:    sw_rdata <= ram_col;
            `CCR_ADDR_TABLE:  sw_rdata <= table_reg;
            `CCR_ADDR_PERIPH: sw_rdata <= periph_sel;
            // bit 3 of the flags word is unused and reads zero
            `CCR_ADDR_FLAGS:  sw_rdata <= {1'b0, branch_cond_flag,
                                           carry_flag, pair_swap_flag};
            // unmapped indexes read zero so nothing leaks out
            default:          sw_rdata <= 4'h0;
         endcase
      end else begin
         sw_rdata <= 4'h0;
      end
   end

endmodule // ccr_core_regs

// ==== verification/ccr_core_regs_properties.sv ====
// checker for the core working registers and condition flags
`include "ccr_core_regs.vh"
module ccr_core_regs_checker (
   // clock and reset
   input wire logic                 clock,
   input wire logic                 arst_n,
   // instruction decoder
   input wire logic                 op_valid,
   input wire logic [`CCR_OP_W-1:0] op_code,
   input wire logic [3:0]           op_data,
   // register and flag state
   input wire logic [3:0]           work_nibble,
   input wire logic                 pair_swap_flag,
   input wire logic                 carry_flag,
   input wire logic                 branch_cond_flag,
   input wire logic                 branch_take,
   // pointers
   input wire logic [7:0]           ram_addr,
   input wire logic [3:0]           rom_table_nib,
   input wire logic [3:0]           periph_reg_n,
   input wire logic [3:0]           pair_a_value,
   input wire logic [3:0]           pair_b_value
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);

   add_carry_a: assert property (
      op_valid && op_code == `CCR_OP_ADD |=> {carry_flag, work_nibble}
      == $past({1'b0, work_nibble} + {1'b0, op_data})
      && branch_cond_flag == carry_flag) else $error("add carry wrong");
   sub_borrow_a: assert property (
      op_valid && op_code == `CCR_OP_SUB |=> carry_flag ==
      ($past(work_nibble) >= $past(op_data))
      && branch_cond_flag == carry_flag) else $error("sub carry wrong");
   carry_force_a: assert property (
      op_valid && op_code inside {`CCR_OP_SET_CARRY, `CCR_OP_CLR_CARRY}
      |=> carry_flag == $past(op_code == `CCR_OP_SET_CARRY)
      && branch_cond_flag == carry_flag) else $error("carry force wrong");
   rotate_left_a: assert property (
      op_valid && op_code == `CCR_OP_ROT_LEFT |=> {carry_flag, work_nibble}
      == $past({work_nibble, carry_flag})
      && branch_cond_flag == carry_flag) else $error("rotate wrong");
   logic_zero_a: assert property (
      op_valid && op_code inside {`CCR_OP_AND, `CCR_OP_OR, `CCR_OP_XOR}
      |=> branch_cond_flag == (work_nibble != 4'h0))
      else $error("logic branch wrong");
   compare_zero_a: assert property (
      op_valid && op_code inside {`CCR_OP_NEQ_TEST, `CCR_OP_COMPARE}
      |=> branch_cond_flag == ($past(work_nibble) != $past(op_data))
      && $stable(work_nibble)) else $error("compare branch wrong");
   load_sets_a: assert property (
      op_valid && op_code == `CCR_OP_LOAD_IMM |=> branch_cond_flag
      && work_nibble == $past(op_data) && $stable(carry_flag))
      else $error("load flags wrong");
   swap_ops_a: assert property (
      op_valid && op_code inside {`CCR_OP_SET_SWAP, `CCR_OP_CLR_SWAP}
      |=> pair_swap_flag == $past(op_code == `CCR_OP_SET_SWAP))
      else $error("swap flag wrong");
   swap_reset_a: assert property (disable iff (1'b0)
      !arst_n |-> !pair_swap_flag) else $error("swap not cleared");
   pair_select_a: assert property (
      pair_a_value === (pair_swap_flag ? rom_table_nib : ram_addr[7:4])
      && pair_b_value === (pair_swap_flag ? periph_reg_n : ram_addr[3:0]))
      else $error("pair select wrong");
   branch_take_a: assert property (
      branch_take === branch_cond_flag) else $error("branch take wrong");

   // main scenarios reached
   cover property (op_valid && op_code == `CCR_OP_ADD ##1 carry_flag);
   cover property (op_valid && op_code == `CCR_OP_SET_SWAP);
   cover property (op_valid && op_code == `CCR_OP_AND ##1 !branch_cond_flag);
endmodule // ccr_core_regs_checker

bind ccr_core_regs ccr_core_regs_checker i_chk (.clock(clock),
   .arst_n(arst_n), .op_valid(op_valid), .op_code(op_code),
   .op_data(op_data), .work_nibble(work_nibble),
   .pair_swap_flag(pair_swap_flag), .carry_flag(carry_flag),
   .branch_cond_flag(branch_cond_flag), .branch_take(branch_take),
   .ram_addr(ram_addr), .rom_table_nib(rom_table_nib),
   .periph_reg_n(periph_reg_n), .pair_a_value(pair_a_value),
   .pair_b_value(pair_b_value));

// ==== verification/ccr_dec_model.sv ====
// decoder model issuing one instruction per call
`include "ccr_core_regs.vh"
module ccr_dec_model (
   // clock
   input  wire logic                 clock,
   // instruction out
   output logic                      op_valid,
   output logic [`CCR_OP_W-1:0]      op_code,
   output logic [3:0]                op_data
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      op_valid = 1'b0;
      op_code = `CCR_OP_NOP;
      op_data = 4'h0;
   end
   // one-cycle pulse; operand is scrambled after so stale data never helps
   task automatic issue(input logic [4:0] c, input logic [3:0] d);
      @(posedge clock);
      op_valid <= 1'b1;
      op_code <= c;
      op_data <= d;
      @(posedge clock);
      op_valid <= 1'b0;
      op_data <= ~d;
   endtask
endmodule // ccr_dec_model

// ==== verification/ccr_core_regs_test.sv ====
// self-checking bench for the core registers and condition flags
`include "ccr_core_regs.vh"
module ccr_core_regs_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic       clock, arst_n, sw_write, sw_read, op_valid;
   logic       pair_swap_flag, carry_flag, branch_cond_flag, branch_take;
   logic [2:0] sw_addr;
   logic [4:0] op_code;
   logic [3:0] op_data, sw_wdata, sw_rdata, work_nibble, rom_table_nib;
   logic [3:0] periph_reg_n, pair_a_value, pair_b_value;
   logic [7:0] ram_addr;
   int         err_count = 0;
   int         checks_done = 0;

   ccr_dec_model i_dec (.clock(clock), .op_valid(op_valid),
      .op_code(op_code), .op_data(op_data));
   ccr_core_regs i_dut (.clock(clock), .arst_n(arst_n),
      .op_valid(op_valid), .op_code(op_code), .op_data(op_data),
      .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_write(sw_write),
      .sw_read(sw_read), .sw_rdata(sw_rdata), .work_nibble(work_nibble),
      .pair_swap_flag(pair_swap_flag), .carry_flag(carry_flag),
      .branch_cond_flag(branch_cond_flag), .ram_addr(ram_addr),
      .rom_table_nib(rom_table_nib), .periph_reg_n(periph_reg_n),
      .pair_a_value(pair_a_value), .pair_b_value(pair_b_value),
      .branch_take(branch_take));

   task automatic chk(input string what, input logic [7:0] e, g);
      checks_done++;
      if (g !== e) begin
         err_count++;
         $display("BAD %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic sw_wr(input logic [2:0] a, input logic [3:0] d);
      @(posedge clock);
      sw_write <= 1'b1;
      sw_addr <= a;
      sw_wdata <= d;
      @(posedge clock);
      sw_write <= 1'b0;
      sw_wdata <= ~d;
   endtask
   // read data is only valid in the cycle after the strobe
   task automatic sw_rd(input logic [2:0] a, input logic [3:0] e);
      @(posedge clock);
      sw_read <= 1'b1;
      sw_addr <= a;
      @(posedge clock);
      sw_read <= 1'b0;
      #1 chk("sw_rdata", {4'h0, e}, {4'h0, sw_rdata});
   endtask
   task automatic op(input logic [4:0] c, input logic [3:0] d, w,
                     input logic cy, br);
      i_dec.issue(c, d);
      #1 chk("work_flags", {w, cy, br, br, 1'b0},
         {work_nibble, carry_flag, branch_cond_flag, branch_take, 1'b0});
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // whole run is about 80 cycles
   initial begin
      repeat (2000) @(posedge clock);
      err_count++;
      report_and_stop();
   end

   initial begin
      arst_n = 1'b0;
      sw_write = 1'b0;
      sw_read = 1'b0;
      sw_addr = 3'h0;
      sw_wdata = 4'h0;
      repeat (2) @(posedge clock);
      arst_n <= 1'b1;
      #1 chk("swap_rdata", 8'h00, {3'h0, pair_swap_flag, sw_rdata});
      chk("work_x", 8'hXX, {2{work_nibble}});
      chk("ptr_x", 8'hXX, ram_addr);
      chk("carry_x", 8'hXX, {8{carry_flag}});
      chk("branch_x", 8'hXX, {8{branch_cond_flag}});
      sw_wr(`CCR_ADDR_WORK, 4'h8);
      sw_rd(`CCR_ADDR_WORK, 4'h8);
      op(`CCR_OP_ADD, 4'h9, 4'h1, 1'b1, 1'b1);
      op(`CCR_OP_ADD, 4'h6, 4'h7, 1'b0, 1'b0);
      op(`CCR_OP_SUB, 4'h9, 4'hE, 1'b0, 1'b0);
      op(`CCR_OP_SUB, 4'h4, 4'hA, 1'b1, 1'b1);
      op(`CCR_OP_CLR_CARRY, 4'h0, 4'hA, 1'b0, 1'b0);
      op(`CCR_OP_SET_CARRY, 4'h0, 4'hA, 1'b1, 1'b1);
      op(`CCR_OP_ROT_LEFT, 4'h0, 4'h5, 1'b1, 1'b1);
      op(`CCR_OP_ROT_RIGHT, 4'h0, 4'hA, 1'b1, 1'b1);
      op(`CCR_OP_CLR_CARRY, 4'h0, 4'hA, 1'b0, 1'b0);
      op(`CCR_OP_LOAD_IMM, 4'h3, 4'h3, 1'b0, 1'b1);
      op(`CCR_OP_AND, 4'hC, 4'h0, 1'b0, 1'b0);
      op(`CCR_OP_OR, 4'h4, 4'h4, 1'b0, 1'b1);
      op(`CCR_OP_XOR, 4'h4, 4'h0, 1'b0, 1'b0);
      op(`CCR_OP_NEQ_TEST, 4'h0, 4'h0, 1'b0, 1'b0);
      op(`CCR_OP_LOAD_IMM, 4'h6, 4'h6, 1'b0, 1'b1);
      op(`CCR_OP_NEQ_TEST, 4'h6, 4'h6, 1'b0, 1'b0);
      op(`CCR_OP_COMPARE, 4'h6, 4'h6, 1'b0, 1'b0);
      op(`CCR_OP_COMPARE, 4'h2, 4'h6, 1'b0, 1'b1);
      sw_wr(`CCR_ADDR_ROW, 4'h3);
      sw_wr(`CCR_ADDR_COL, 4'hC);
      sw_wr(`CCR_ADDR_TABLE, 4'h5);
      sw_wr(`CCR_ADDR_PERIPH, 4'h9);
      #1 chk("ram_addr", 8'h3C, ram_addr);
      chk("table_periph", 8'h59, {rom_table_nib, periph_reg_n});
      chk("pairs", 8'h3C, {pair_a_value, pair_b_value});
      op(`CCR_OP_SET_SWAP, 4'h0, 4'h6, 1'b0, 1'b1);
      chk("pairs", 8'h59, {pair_a_value, pair_b_value});
      op(`CCR_OP_WR_PAIR_A, 4'hE, 4'h6, 1'b0, 1'b1);
      chk("table_periph", 8'hE9, {rom_table_nib, periph_reg_n});
      chk("ram_addr", 8'h3C, ram_addr);
      op(`CCR_OP_CLR_SWAP, 4'h0, 4'h6, 1'b0, 1'b1);
      chk("pairs", 8'h3C, {pair_a_value, pair_b_value});
      op(`CCR_OP_PROT_LEFT, 4'h0, 4'h6, 1'b0, 1'b0);
      chk("ram_addr", 8'h6C, ram_addr);
      op(`CCR_OP_PROT_RIGHT, 4'h0, 4'h6, 1'b0, 1'b0);
      chk("ram_addr", 8'h3C, ram_addr);
      op(`CCR_OP_TO_PAIR_B, 4'h0, 4'h6, 1'b0, 1'b1);
      chk("ram_addr", 8'h36, ram_addr);
      op(`CCR_OP_FROM_PAIR_A, 4'h0, 4'h3, 1'b0, 1'b1);
      op(`CCR_OP_WR_PAIR_B, 4'h1, 4'h3, 1'b0, 1'b1);
      chk("ram_addr", 8'h31, ram_addr);
      op(`CCR_OP_FROM_PAIR_B, 4'h0, 4'h1, 1'b0, 1'b1);
      op(`CCR_OP_NOP, 4'h0, 4'h1, 1'b0, 1'b1);
      op(`CCR_OP_BRANCH, 4'h0, 4'h1, 1'b0, 1'b1);
      sw_rd(`CCR_ADDR_FLAGS, 4'h4);
      sw_rd(3'h6, 4'h0);
      sw_wr(`CCR_ADDR_FLAGS, 4'h3);
      sw_rd(`CCR_ADDR_FLAGS, 4'h3);
      // mid-run reset: swap clears, carry keeps its value
      @(posedge clock);
      arst_n <= 1'b0;
      @(posedge clock);
      arst_n <= 1'b1;
      #1 chk("swap_rdata", 8'h00, {3'h0, pair_swap_flag, sw_rdata});
      chk("carry_kept", 8'hFF, {8{carry_flag}});
      report_and_stop();
   end
endmodule // ccr_core_regs_test
